// *** pkg/irap_pkg.sv ***
// Package for the two-wire register access port: constants and carriers
`default_nettype none
package irap_pkg;
  localparam logic [4:0] IRAP_ADDR_FIXED = 5'h13;
  localparam logic [6:0] IRAP_INDEX_LAST = 7'h7f;
  localparam logic [6:0] IRAP_INDEX_RST  = 7'h00;
  localparam logic [7:0] IRAP_PAGE_RST   = 8'h00;
  localparam logic [6:0] IRAP_PAGE_REG   = 7'h00;
  localparam logic [2:0] IRAP_BIT_LAST   = 3'h7;
  localparam int         IRAP_AINC_POS   = 7;

  typedef enum logic [2:0] {
    IRAP_IDLE  = 3'b000,
    IRAP_ADDR  = 3'b001,
    IRAP_AACK  = 3'b011,
    IRAP_WBYTE = 3'b010,
    IRAP_WACK  = 3'b110,
    IRAP_RBYTE = 3'b111,
    IRAP_RACK  = 3'b101
  } irap_state_t;

  // Access toward the register file behind the port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [6:0] index;
    logic [7:0] wdata;
  } irap_req_t;

  // Open-drain data pin
  typedef struct packed {
    logic o;
    logic oe;
  } irap_pin_t;
endpackage
`default_nettype wire

// *** src/irap_port.sv ***
// Two-wire slave port giving byte access to paged registers
// What this block does
// - Auto-increment advances index after written byte
// - Index wraps from 0x7f to 0x00
// - Read after repeated start returns indexed byte
// - Auto-increment advances index as each byte is loaded to send
// - Acknowledge own address, index and data
// - Configuration only through this two-wire port
// - Address is 10011 plus two select pins
// - Slave only, never drives the bus clock
// - Register zero selects page 0 to 255
`default_nettype none
module irap_port
  import irap_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // Bus pins, clock is input only
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output irap_pkg::irap_pin_t    sda_pin,
  // Address-select straps
  input  wire logic              address_select_high_pin,
  input  wire logic              address_select_low_pin,
  // Register file side
  output irap_pkg::irap_req_t    reg_req,
  input  wire logic [7:0]        reg_rdata,
  output logic      [7:0]        page_sel
);
  import irap_pkg::*;

  function automatic logic [6:0] next_index(input logic [6:0] idx);
    next_index = (idx == IRAP_INDEX_LAST) ? IRAP_INDEX_RST : idx + 7'h01;
  endfunction

  // Two-stage synchronisers on every pin
  logic [1:0] scl_s_q, sda_s_q, a1_s_q, a0_s_q;
  logic       scl_q, sda_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      a1_s_q  <= 2'h0;
      a0_s_q  <= 2'h0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      a1_s_q  <= {a1_s_q[0], address_select_high_pin};
      a0_s_q  <= {a0_s_q[0], address_select_low_pin};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_cond, stop_cond;
  assign scl        = scl_s_q[1];
  assign sda        = sda_s_q[1];
  assign scl_rise   = scl && !scl_q;
  assign scl_fall   = !scl && scl_q;
  assign start_cond = scl && scl_q && sda_q && !sda;
  assign stop_cond  = scl && scl_q && !sda_q && sda;

  irap_state_t state_q, state_d;
  logic [7:0]  shift_q, shift_d;
  logic [2:0]  bitc_q, bitc_d;
  logic [6:0]  index_q, index_d;
  logic        ainc_q, ainc_d;
  logic        have_idx_q, have_idx_d;
  logic        drive_q, drive_d;
  logic        rnack_q, rnack_d;
  logic [7:0]  page_q, page_d;
  irap_req_t   req_q, req_d;
  logic [6:0]  my_addr;

  assign my_addr = {IRAP_ADDR_FIXED, a1_s_q[1], a0_s_q[1]};

  always_comb begin
    state_d    = state_q;
    shift_d    = shift_q;
    bitc_d     = bitc_q;
    index_d    = index_q;
    ainc_d     = ainc_q;
    have_idx_d = have_idx_q;
    drive_d    = drive_q;
    rnack_d    = rnack_q;
    page_d     = page_q;
    req_d      = req_q;
    req_d.wr   = 1'b0;
    req_d.rd   = 1'b0;
    req_d.page = page_q;
    if (stop_cond) begin
      state_d = IRAP_IDLE;
      drive_d = 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the index loaded earlier
      state_d    = IRAP_ADDR;
      bitc_d     = 3'h0;
      shift_d    = 8'h00; // Stale byte must not pass as an address
      drive_d    = 1'b0;
      have_idx_d = 1'b0;
    end else begin
      case (state_q)
        IRAP_IDLE: begin
          drive_d = 1'b0;
        end
        IRAP_ADDR, IRAP_WBYTE: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda};
            bitc_d  = bitc_q + 3'h1;
          end else if (scl_fall && bitc_q == 3'h0 && shift_q != 8'h00
                       || scl_fall && bitc_q == 3'h0 && state_q == IRAP_WBYTE
                          && shift_q == 8'h00) begin
            if (state_q == IRAP_ADDR) begin
              if (shift_q[7:1] == my_addr) begin
                drive_d = 1'b1;
                state_d = IRAP_AACK;
              end else begin
                state_d = IRAP_IDLE;
              end
            end else begin
              drive_d = 1'b1;
              state_d = IRAP_WACK;
              if (!have_idx_q) begin
                ainc_d     = shift_q[IRAP_AINC_POS];
                index_d    = shift_q[6:0];
                have_idx_d = 1'b1;
              end else begin
                req_d.wr    = 1'b1;
                req_d.index = index_q;
                req_d.wdata = shift_q;
                if (index_q == IRAP_PAGE_REG) begin
                  page_d = shift_q;
                end
                if (ainc_q) begin
                  index_d = next_index(index_q);
                end
              end
            end
          end
        end
        IRAP_AACK: begin
          if (scl_fall) begin
            bitc_d = 3'h0;
            if (shift_q[0]) begin
              // Data sampled from the register file now
              state_d = IRAP_RBYTE;
              shift_d = reg_rdata;
              req_d.rd    = 1'b1;
              req_d.index = index_q;
              drive_d = !reg_rdata[7];
              if (ainc_q) begin
                index_d = next_index(index_q);
              end
            end else begin
              state_d = IRAP_WBYTE;
              drive_d = 1'b0;
            end
          end
        end
        IRAP_WACK: begin
          if (scl_fall) begin
            drive_d = 1'b0;
            bitc_d  = 3'h0;
            state_d = IRAP_WBYTE;
          end
        end
        IRAP_RBYTE: begin
          if (scl_fall) begin
            if (bitc_q == IRAP_BIT_LAST) begin
              drive_d = 1'b0;
              state_d = IRAP_RACK;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              drive_d = !shift_q[6];
            end
            bitc_d = bitc_q + 3'h1;
          end
        end
        IRAP_RACK: begin
          if (scl_rise) begin
            rnack_d = sda;
          end else if (scl_fall) begin
            if (rnack_q) begin
              state_d = IRAP_IDLE;
            end else begin
              state_d = IRAP_RBYTE;
              shift_d = reg_rdata;
              req_d.rd    = 1'b1;
              req_d.index = index_q;
              drive_d = !reg_rdata[7];
              if (ainc_q) begin
                index_d = next_index(index_q);
              end
            end
          end
        end
        default: state_d = IRAP_IDLE;
      endcase
    end
    req_d.page = page_d;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= IRAP_IDLE;
      shift_q    <= 8'h00;
      bitc_q     <= 3'h0;
      index_q    <= IRAP_INDEX_RST;
      ainc_q     <= 1'b0;
      have_idx_q <= 1'b0;
      drive_q    <= 1'b0;
      rnack_q    <= 1'b0;
      page_q     <= IRAP_PAGE_RST;
      req_q      <= '0;
    end else if (clk_en) begin
      state_q    <= state_d;
      shift_q    <= shift_d;
      bitc_q     <= bitc_d;
      index_q    <= index_d;
      ainc_q     <= ainc_d;
      have_idx_q <= have_idx_d;
      drive_q    <= drive_d;
      rnack_q    <= rnack_d;
      page_q     <= page_d;
      req_q      <= req_d;
    end
  end

  // Open-drain: only ever pulls low; sole config path
  assign sda_pin.o  = 1'b0;
  assign sda_pin.oe = drive_q;
  assign reg_req    = req_q;
  assign page_sel   = page_q;

  a_index_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && req_d.wr && ainc_q && index_q == IRAP_INDEX_LAST
    |=> index_q == IRAP_INDEX_RST)
    else $error("index did not wrap");
  a_index_hold: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && (req_d.wr || req_d.rd) && !ainc_q |=> $stable(index_q))
    else $error("index moved without auto-increment");
  a_index_step: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && req_d.wr && ainc_q && index_q != IRAP_INDEX_LAST
    |=> index_q == $past(index_q) + 7'h01)
    else $error("index did not advance");
  a_ack_drive: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && state_q == IRAP_WACK && !scl_fall && !start_cond && !stop_cond
    |=> drive_q)
    else $error("acknowledge released early");
  a_page_load: assert property (@(posedge core_clk) disable iff (!resetn)
    req_q.wr && req_q.index == IRAP_PAGE_REG |-> page_q == req_q.wdata)
    else $error("page not loaded");
  a_read_step: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && req_d.rd && ainc_q |=> index_q == next_index($past(index_q)))
    else $error("read index did not advance");
  a_nack_ends: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && state_q == IRAP_RACK && rnack_q && scl_fall && !start_cond
      && !stop_cond |=> state_q == IRAP_IDLE)
    else $error("read not ended on nack");
  sequence s_addr_taken;
    state_q == IRAP_ADDR ##1 state_q == IRAP_AACK;
  endsequence
  a_addr_match: assert property (@(posedge core_clk) disable iff (!resetn)
    s_addr_taken |-> $past(shift_q[7:1]) == my_addr)
    else $error("acknowledged foreign address");
endmodule
`default_nettype wire

// *** dv/irap_master.sv ***
// Two-wire bus master model driving clock and data toward the port
`default_nettype none
module irap_master (
  // Clock and bus wire
  input  wire logic core_clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Eight cycles a phase, above the six the port needs
  task automatic ph();
    repeat (8) @(posedge core_clk);
    #1;
  endtask
  // Also a repeated start: data released before clock rises
  task automatic start();
    ph();
    sda_low = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b0;
  endtask
  task automatic stop();
    ph();
    sda_low = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_low = 1'b0;
    ph();
  endtask
  // Data moves only a phase after the clock fell, for hold margin
  task automatic bit1(input logic b, output logic r);
    ph();
    sda_low = ~b;
    ph();
    scl = 1'b1;
    ph();
    r = sda;
    scl = 1'b0;
  endtask
  // Eight bits MSB first, then the ninth as given
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
    bit1(last, ack);
  endtask
endmodule
`default_nettype wire

// *** dv/irap_port_bench.sv ***
// Self-checking bench for the two-wire register access port
`default_nettype none
module irap_port_bench;
  import irap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic [1:0] sel      = 2'b00;
  logic       scl;
  logic       sda_low;
  logic       sda;
  irap_pin_t  sda_pin;
  irap_req_t  reg_req;
  logic [7:0] page_sel;
  logic [7:0] reg_rdata;
  logic [6:0] mdl_idx  = 7'h00;
  logic       clk_en   = 1'b1;
  logic [7:0] last_page = 8'h00;
  logic [14:0] wq[$];
  logic [6:0] rq[$];
  int fails = 0;
  int check_count = 0;
  always #12.5 core_clk = ~core_clk;
  // Pulled-up wire; an unknown enable stays unknown while the master releases
  assign sda = ~(sda_pin.oe | sda_low);
  assign reg_rdata = {1'b1, mdl_idx} ^ 8'h5a;
  always @(posedge core_clk) begin
    if (reg_req.wr === 1'b1) begin
      wq.push_back({reg_req.index, reg_req.wdata});
      last_page <= reg_req.page;
    end
    if (reg_req.rd === 1'b1) begin
      rq.push_back(reg_req.index);
      mdl_idx <= mdl_idx + 7'h01;
    end
  end
  irap_port irap_port_inst (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .scl_in(scl), .sda_in(sda), .sda_pin(sda_pin),
    .address_select_high_pin(sel[1]), .address_select_low_pin(sel[0]),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .page_sel(page_sel));
  irap_master irap_master_inst (
    .core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xb(input logic [7:0] d, input logic nack);
    logic [7:0] q;
    logic a;
    irap_master_inst.xfer(d, 1'b1, q, a);
    chk({14'h0000, a}, {14'h0000, nack});
  endtask
  task automatic wbytes(input logic [7:0] ib, input int n);
    irap_master_inst.start();
    xb({IRAP_ADDR_FIXED, sel, 1'b0}, 1'b0);
    xb(ib, 1'b0);
    for (int i = 0; i < n; i++) xb(8'h30 + 8'(i), 1'b0);
    if (n > 0) irap_master_inst.stop();
  endtask
  task automatic wcheck(input logic [6:0] s, input logic inc, input int n);
    logic [14:0] e;
    chk(15'(wq.size()), 15'(n));
    for (int i = 0; i < n; i++) begin
      e = wq.pop_front();
      chk(e, {s + (inc ? 7'(i) : 7'h00), 8'h30 + 8'(i)});
    end
  endtask
  task automatic test_winc();
    wbytes({1'b1, 7'h7e}, 3);
    wcheck(7'h7e, 1'b1, 3);
    chk({7'h00, page_sel}, 15'h0032);
    $display("test_winc done");
  endtask
  task automatic test_wfix();
    wbytes({1'b0, 7'h05}, 2);
    wcheck(7'h05, 1'b0, 2);
    chk({7'h00, last_page}, 15'h0032);
    $display("test_wfix done");
  endtask
  task automatic test_read();
    logic [7:0] q;
    logic a;
    mdl_idx = 7'h7f;
    wbytes({1'b1, 7'h7f}, 0);
    irap_master_inst.start();
    xb({IRAP_ADDR_FIXED, sel, 1'b1}, 1'b0);
    irap_master_inst.xfer(8'hff, 1'b0, q, a);
    chk({7'h00, q}, 15'h00a5);
    irap_master_inst.xfer(8'hff, 1'b1, q, a);
    chk({7'h00, q}, 15'h00da);
    irap_master_inst.stop();
    chk(15'(rq.size()), 15'h0002);
    chk({8'h00, rq[0]}, 15'h007f);
    chk({8'h00, rq[1]}, 15'h0000);
    chk({14'h0000, sda_pin.oe}, 15'h0000);
    chk({14'h0000, sda_pin.o}, 15'h0000);
    $display("test_read done");
  endtask
  task automatic test_addr();
    for (int p = 0; p < 4; p++) begin
      sel = 2'(p);
      repeat (6) @(posedge core_clk);
      #1;
      irap_master_inst.start();
      xb({IRAP_ADDR_FIXED, sel ^ 2'b01, 1'b0}, 1'b1);
      irap_master_inst.stop();
      wbytes({1'b1, 7'h10 + 7'(p)}, 1);
      wcheck(7'h10 + 7'(p), 1'b1, 1);
    end
    $display("test_addr done");
  endtask
  task automatic test_rfix();
    logic [7:0] q;
    logic a;
    mdl_idx = 7'h20;
    wbytes({1'b0, 7'h20}, 0);
    irap_master_inst.start();
    xb({IRAP_ADDR_FIXED, sel, 1'b1}, 1'b0);
    irap_master_inst.xfer(8'hff, 1'b0, q, a);
    chk({7'h00, q}, 15'h00fa);
    irap_master_inst.xfer(8'hff, 1'b1, q, a);
    irap_master_inst.stop();
    chk(15'(rq.size()), 15'h0004);
    chk({8'h00, rq[2]}, 15'h0020);
    chk({8'h00, rq[3]}, 15'h0020);
    $display("test_rfix done");
  endtask
  // Frozen port must ignore a whole write to the page register
  task automatic test_freeze();
    clk_en = 1'b0;
    irap_master_inst.start();
    xb({IRAP_ADDR_FIXED, sel, 1'b0}, 1'b1);
    xb(8'h80, 1'b1);
    xb(8'h77, 1'b1);
    irap_master_inst.stop();
    clk_en = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk(15'(wq.size()), 15'h0000);
    chk({7'h00, page_sel}, 15'h0032);
    chk({14'h0000, sda_pin.oe}, 15'h0000);
    $display("test_freeze done");
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // About four times the expected run
  initial begin
    #1000000;
    fails++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 resetn = 1'b1;
    chk({7'h00, page_sel}, 15'h0000);
    repeat (6) @(posedge core_clk);
    #1;
    test_winc();
    test_wfix();
    test_read();
    test_rfix();
    test_addr();
    test_freeze();
    test_done();
  end
endmodule
`default_nettype wire
